// File: hw/accel_rate_and_output_setup.sv
// Rate selection and output setup registers with data-ready timing and axis outputs.
// Assumes the serial front end presents decoded one-cycle register requests,
// and that the power-control register lives outside and is passed in as levels.
`timescale 1ns/10ps
module accel_rate_and_output_setup #(
	// Cycles per microsecond tick; a smaller value shortens every interval alike
	parameter int CYCLES_PER_US = accel_rate_pkg::CYCLES_PER_US
) (
	input  wire logic                       clk_sys,
	input  wire logic                       rst_b,
	input  accel_rate_pkg::reg_req_s        reg_req,
	output logic [7:0]                      reg_rdata_r,
	input  wire logic                       power_suspend,
	input  wire logic [3:0]                 sleep_length_code,
	input  wire logic                       sample_valid,
	input  accel_rate_pkg::axis_set_s       filtered_sample,
	input  accel_rate_pkg::axis_set_s       unfiltered_sample,
	output logic [19:0]                     active_interval_us_r,
	output logic                            active_rate_fixed_r,
	output logic [19:0]                     sleep_interval_us_r,
	output logic                            data_ready_r,
	output logic                            unfiltered_sel_r,
	output logic                            guard_off_r
);

	localparam int IW = accel_rate_pkg::INTERVAL_W;

	logic [7:0]    rate_select_r;
	logic [7:0]    rate_select_nxt;
	logic [7:0]    output_setup_r;
	logic [7:0]    output_setup_nxt;
	logic [7:0]    rdata_nxt;
	logic [2:0]    active_rate_code;
	logic          sleep_rate_source;
	logic [IW-1:0] active_us;
	logic [IW-1:0] sleep_us;
	logic [47:0]   axis_source;
	logic [7:0]    low_bytes  [3];
	logic [7:0]    high_bytes [3];

	assign active_rate_code  = rate_select_r[accel_rate_pkg::ACTIVE_RATE_CODE_MSB:0];
	assign sleep_rate_source = rate_select_r[accel_rate_pkg::SLEEP_RATE_SOURCE_BIT];

	// ----------------------------------------------------------------
	// Interval tables in microseconds
	// ----------------------------------------------------------------
	// Fixed active intervals; code zero leaves the interval to the sleep setting
	function automatic logic [IW-1:0] active_interval(input logic [2:0] code);
		case (code)
			3'h1:    active_interval = 20'd5000;   // 200 Hz
			3'h2:    active_interval = 20'd1000;   // 1000 Hz
			3'h3:    active_interval = 20'd2000;   // 500 Hz
			3'h4:    active_interval = 20'd4000;   // 250 Hz
			3'h5:    active_interval = 20'd8000;   // 125 Hz
			3'h6:    active_interval = 20'd16000;  // 62.5 Hz
			3'h7:    active_interval = 20'd32000;  // 31.25 Hz
			default: active_interval = 20'd0;
		endcase
	endfunction

	// Sleep interval derived from the selected rate; 302 Hz is truncated to whole microseconds
	function automatic logic [IW-1:0] sleep_rate_interval(input logic [3:0] code);
		case (code)
			4'h7:       sleep_rate_interval = 20'd5000;     // 200 Hz
			4'h8, 4'h9: sleep_rate_interval = 20'd10000;    // 100 Hz
			4'hA:       sleep_rate_interval = 20'd20000;    // 50 Hz
			4'hB:       sleep_rate_interval = 20'd40000;    // 25 Hz
			4'hC:       sleep_rate_interval = 20'd50000;    // 20 Hz
			4'hD:       sleep_rate_interval = 20'd100000;   // 10 Hz
			4'hE:       sleep_rate_interval = 20'd500000;   // 2 Hz
			4'hF:       sleep_rate_interval = 20'd1000000;  // 1 Hz
			default:    sleep_rate_interval = 20'd3311;     // 302 Hz
		endcase
	endfunction

	// Sleep durations of the power-control register
	function automatic logic [IW-1:0] sleep_duration(input logic [3:0] code);
		case (code)
			4'h7:    sleep_duration = 20'd2000;
			4'h8:    sleep_duration = 20'd4000;
			4'h9:    sleep_duration = 20'd6000;
			4'hA:    sleep_duration = 20'd10000;
			4'hB:    sleep_duration = 20'd25000;
			4'hC:    sleep_duration = 20'd50000;
			4'hD:    sleep_duration = 20'd100000;
			4'hE:    sleep_duration = 20'd500000;
			4'hF:    sleep_duration = 20'd1000000;
			default: sleep_duration = 20'd1000;
		endcase
	endfunction

	// Sleep interval source select
	always_comb begin
		active_us = active_interval(active_rate_code);
		if (sleep_rate_source) begin
			sleep_us = sleep_rate_interval(sleep_length_code);
		end else begin
			sleep_us = sleep_duration(sleep_length_code);
		end
	end

	// ----------------------------------------------------------------
	// Register writes and reads
	// ----------------------------------------------------------------
	// Writes are taken in any power state; correct samples after a rate change
	// are the host's affair, so no write is refused here
	always_comb begin
		rate_select_nxt  = rate_select_r;
		output_setup_nxt = output_setup_r;
		rdata_nxt        = 8'h00;
		if (reg_req.wr) begin
			if (reg_req.addr == accel_rate_pkg::ADDR_RATE_SELECT) begin
				rate_select_nxt = reg_req.wdata & accel_rate_pkg::RATE_SELECT_WMASK;
			end else if (reg_req.addr == accel_rate_pkg::ADDR_OUTPUT_SETUP) begin
				output_setup_nxt = reg_req.wdata & accel_rate_pkg::OUTPUT_SETUP_WMASK;
			end else if (reg_req.addr == accel_rate_pkg::ADDR_SOFT_RESET &&
			             reg_req.wdata == accel_rate_pkg::SOFT_RESET_KEY) begin
				rate_select_nxt  = accel_rate_pkg::RATE_SELECT_RST;
				output_setup_nxt = accel_rate_pkg::OUTPUT_SETUP_RST;
			end
		end
		if (reg_req.rd) begin
			if (reg_req.addr == accel_rate_pkg::ADDR_RATE_SELECT) begin
				rdata_nxt = rate_select_r;
			end else if (reg_req.addr == accel_rate_pkg::ADDR_OUTPUT_SETUP) begin
				rdata_nxt = output_setup_r;
			end else begin
				for (int i = 0; i < 3; i++) begin
					if (reg_req.addr == accel_rate_pkg::ADDR_AXIS_BASE + 8'(2 * i)) begin
						rdata_nxt = low_bytes[i];
					end else if (reg_req.addr == accel_rate_pkg::ADDR_AXIS_BASE + 8'(2 * i + 1)) begin
						rdata_nxt = high_bytes[i];
					end
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rate_select_r        <= accel_rate_pkg::RATE_SELECT_RST;
			output_setup_r       <= accel_rate_pkg::OUTPUT_SETUP_RST;
			reg_rdata_r          <= 8'h00;
			active_interval_us_r <= 20'd0;
			active_rate_fixed_r  <= 1'b0;
			sleep_interval_us_r  <= 20'd0;
			unfiltered_sel_r     <= 1'b0;
			guard_off_r          <= 1'b0;
		end else begin
			rate_select_r        <= rate_select_nxt;
			output_setup_r       <= output_setup_nxt;
			reg_rdata_r          <= rdata_nxt;
			active_interval_us_r <= active_us;
			active_rate_fixed_r  <= (active_rate_code != 3'h0);
			sleep_interval_us_r  <= sleep_us;
			unfiltered_sel_r     <= output_setup_r[accel_rate_pkg::UNFILTERED_BIT];
			guard_off_r          <= output_setup_r[accel_rate_pkg::COHERENCE_GUARD_OFF_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Data-ready timing
	// ----------------------------------------------------------------
	accel_rate_pkg::ready_state_e ready_state_r;
	accel_rate_pkg::ready_state_e ready_state_nxt;
	logic [7:0]    us_cnt_r;
	logic [7:0]    us_cnt_nxt;
	logic [IW-1:0] interval_cnt_r;
	logic [IW-1:0] interval_cnt_nxt;
	logic          data_ready_nxt;
	logic          us_tick;

	// Counters restart on every state change; a rate change between two nonzero codes keeps the running count
	always_comb begin
		ready_state_nxt  = ready_state_r;
		us_cnt_nxt       = 8'h00;
		interval_cnt_nxt = '0;
		data_ready_nxt   = 1'b0;
		us_tick          = (us_cnt_r == 8'(CYCLES_PER_US - 1));
		if (power_suspend) begin
			ready_state_nxt = accel_rate_pkg::DR_SUSPEND;
		end else if (active_rate_code == 3'h0) begin
			ready_state_nxt = accel_rate_pkg::DR_IDLE;
		end else begin
			ready_state_nxt = accel_rate_pkg::DR_RUN;
		end
		case (ready_state_r)
			accel_rate_pkg::DR_RUN: begin
				if (ready_state_nxt == accel_rate_pkg::DR_RUN) begin
					us_cnt_nxt       = us_tick ? 8'h00 : us_cnt_r + 8'h01;
					interval_cnt_nxt = interval_cnt_r;
					if (us_tick) begin
						if (interval_cnt_r >= active_interval_us_r - 20'd1) begin
							interval_cnt_nxt = '0;
							data_ready_nxt   = 1'b1;
						end else begin
							interval_cnt_nxt = interval_cnt_r + 20'd1;
						end
					end
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ready_state_r  <= accel_rate_pkg::DR_IDLE;
			us_cnt_r       <= 8'h00;
			interval_cnt_r <= '0;
			data_ready_r   <= 1'b0;
		end else begin
			ready_state_r  <= ready_state_nxt;
			us_cnt_r       <= us_cnt_nxt;
			interval_cnt_r <= interval_cnt_nxt;
			data_ready_r   <= data_ready_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Axis output byte pairs
	// ----------------------------------------------------------------
	// Source chosen from the registered select, one cycle behind the register write
	assign axis_source = unfiltered_sel_r ? unfiltered_sample : filtered_sample;

	for (genvar g = 0; g < 3; g++) begin : g_axis
		localparam logic [7:0] LOW_ADDR  = accel_rate_pkg::ADDR_AXIS_BASE + 8'(2 * g);
		localparam logic [7:0] HIGH_ADDR = accel_rate_pkg::ADDR_AXIS_BASE + 8'(2 * g + 1);
		axis_byte_guard u_guard (
			.clk_sys      (clk_sys),
			.rst_b        (rst_b),
			.guard_en     (!guard_off_r),
			.sample_valid (sample_valid),
			.sample       (axis_source[16*g +: 16]),
			.low_read     (reg_req.rd && reg_req.addr == LOW_ADDR),
			.high_read    (reg_req.rd && reg_req.addr == HIGH_ADDR),
			.low_byte_r   (low_bytes[g]),
			.high_byte_r  (high_bytes[g])
		);
	end

endmodule // accel_rate_and_output_setup

// File: hw/axis_byte_guard.sv
// One axis output byte pair with read coherence protection.
// Assumes low and high read strobes are one-cycle pulses that never coincide.
`timescale 1ns/10ps
module axis_byte_guard (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        guard_en,
	input  wire logic        sample_valid,
	input  wire logic [15:0] sample,
	input  wire logic        low_read,
	input  wire logic        high_read,
	output logic      [7:0]  low_byte_r,
	output logic      [7:0]  high_byte_r
);

	accel_rate_pkg::guard_state_e state_r;
	accel_rate_pkg::guard_state_e state_nxt;
	logic [7:0] low_nxt;
	logic [7:0] high_nxt;
	logic       may_update;

	// ----------------------------------------------------------------
	// Lock and update
	// ----------------------------------------------------------------
	// Update is also blocked in the low read cycle itself, else a sample landing there
	// would pair the captured low byte with a newer high byte
	always_comb begin
		state_nxt  = state_r;
		may_update = 1'b1;
		if (guard_en) begin
			case (state_r)
				accel_rate_pkg::GUARD_OPEN: begin
					if (low_read) begin
						state_nxt  = accel_rate_pkg::GUARD_LOCKED;
						may_update = 1'b0;
					end
				end
				accel_rate_pkg::GUARD_LOCKED: begin
					may_update = high_read;
					if (high_read) begin
						state_nxt = accel_rate_pkg::GUARD_OPEN;
					end
				end
				default: state_nxt = accel_rate_pkg::GUARD_OPEN;
			endcase
		end else begin
			state_nxt = accel_rate_pkg::GUARD_OPEN;
		end
		low_nxt  = low_byte_r;
		high_nxt = high_byte_r;
		if (sample_valid && may_update) begin
			low_nxt  = sample[7:0];
			high_nxt = sample[15:8];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_r     <= accel_rate_pkg::GUARD_OPEN;
			low_byte_r  <= 8'h00;
			high_byte_r <= 8'h00;
		end else begin
			state_r     <= state_nxt;
			low_byte_r  <= low_nxt;
			high_byte_r <= high_nxt;
		end
	end

endmodule // axis_byte_guard

// File: pkg/accel_rate_pkg.sv
// Constants, types and state codes for the rate and output setup block.
// Assumes a single 250 MHz system clock and an internal byte-wide register port.
package accel_rate_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_RATE_SELECT  = 8'h12;
	localparam logic [7:0] ADDR_OUTPUT_SETUP = 8'h13;
	localparam logic [7:0] ADDR_SOFT_RESET   = 8'h14;
	localparam logic [7:0] ADDR_AXIS_BASE    = 8'h02;  // x low, x high, y low, y high, z low, z high
	localparam logic [7:0] SOFT_RESET_KEY    = 8'hB6;
	localparam logic [7:0] RATE_SELECT_RST   = 8'h00;
	localparam logic [7:0] OUTPUT_SETUP_RST  = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int SLEEP_RATE_SOURCE_BIT   = 3;
	localparam int ACTIVE_RATE_CODE_MSB    = 2;
	localparam int UNFILTERED_BIT          = 7;
	localparam int COHERENCE_GUARD_OFF_BIT = 6;
	localparam logic [7:0] RATE_SELECT_WMASK  = 8'h0F;
	localparam logic [7:0] OUTPUT_SETUP_WMASK = 8'hC0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int US_NS         = 1000;
	localparam int CYCLES_PER_US = US_NS / CLK_PERIOD_NS;
	localparam int INTERVAL_W    = 20;  // Microseconds, enough for one second

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic [15:0] z;
		logic [15:0] y;
		logic [15:0] x;
	} axis_set_s;

	typedef enum logic [2:0] {
		DR_SUSPEND = 3'h1,
		DR_IDLE    = 3'h2,
		DR_RUN     = 3'h4
	} ready_state_e;

	typedef enum logic [1:0] {
		GUARD_OPEN   = 2'h1,
		GUARD_LOCKED = 2'h2
	} guard_state_e;

endpackage

// File: testbench/accel_rate_asserts.sv
// Checker for the rate and output setup block, bound to its ports.
// Assumes one clock domain; shadows the writable fields from host writes.
`timescale 1ns/10ps
module accel_rate_asserts (
	input wire logic	clk_sys,
	input wire logic	rst_b,
	input accel_rate_pkg::reg_req_s	reg_req,
	input wire logic [7:0]	reg_rdata_r,
	input wire logic	power_suspend,
	input wire logic [3:0]	sleep_length_code,
	input wire logic [19:0]	active_interval_us_r,
	input wire logic	active_rate_fixed_r,
	input wire logic [19:0]	sleep_interval_us_r,
	input wire logic	data_ready_r,
	input wire logic	unfiltered_sel_r,
	input wire logic	guard_off_r
);
	// ------------------------------------------------------------
	// Field shadow: unfiltered, guard off, sleep source, active code
	// ------------------------------------------------------------
	logic [5:0]	sh_r;
	logic [5:0]	sh_nxt;
	logic	rd12;
	logic	rd13;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// Read strobes of the two setup registers
	assign rd12 = reg_req.rd && reg_req.addr == accel_rate_pkg::ADDR_RATE_SELECT;
	assign rd13 = reg_req.rd && reg_req.addr == accel_rate_pkg::ADDR_OUTPUT_SETUP;
	// Reserved bits never reach the shadow, so read-back checks them too
	always_comb begin
		sh_nxt = sh_r;
		if (reg_req.wr && reg_req.addr == accel_rate_pkg::ADDR_RATE_SELECT) begin
			sh_nxt[3:0] = reg_req.wdata[3:0];
		end
		if (reg_req.wr && reg_req.addr == accel_rate_pkg::ADDR_OUTPUT_SETUP) begin
			sh_nxt[5:4] = reg_req.wdata[7:6];
		end
		if (reg_req.wr && reg_req.addr == accel_rate_pkg::ADDR_SOFT_RESET
			&& reg_req.wdata == accel_rate_pkg::SOFT_RESET_KEY) begin
			sh_nxt = 6'h00;
		end
	end
	// Shadow register
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sh_r <= 6'h00;
		end else begin
			sh_r <= sh_nxt;
		end
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	sequence slp_st;
		($stable(sh_r[3]) && $stable(sleep_length_code))[*3];
	endsequence
	rate_read_a: assert property ($past(rd12) |-> reg_rdata_r == {4'h0, $past(sh_r[3:0])})
		else $error("rate select read back wrong");
	setup_read_a: assert property ($past(rd13) |-> reg_rdata_r == {$past(sh_r[5:4]), 6'h00})
		else $error("output setup read back wrong");
	rdata_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata_r == 8'h00)
		else $error("read data not idle");
	unf_copy_a: assert property ($stable(sh_r[5])[*3] |-> unfiltered_sel_r == sh_r[5])
		else $error("unfiltered select not following register");
	guard_copy_a: assert property ($stable(sh_r[4])[*3] |-> guard_off_r == sh_r[4])
		else $error("guard off not following register");
	rate_fixed_a: assert property ($stable(sh_r[2:0])[*3] |-> active_rate_fixed_r == (sh_r[2:0] != 3'h0))
		else $error("fixed rate flag wrong");
	rate_fast_a: assert property (($stable(sh_r[2:0])[*3]) ##0 (sh_r[2:0] == 3'h2)
		|-> active_interval_us_r == 20'h003E8) else $error("active interval wrong");
	sleep_auto_a: assert property (slp_st ##0 (sh_r[3] && sleep_length_code < 4'h7)
		|-> sleep_interval_us_r == 20'h00CEF) else $error("rate based sleep wrong");
	sleep_pwr_a: assert property (slp_st ##0 (!sh_r[3] && sleep_length_code == 4'hF)
		|-> sleep_interval_us_r == 20'hF4240) else $error("power based sleep wrong");
	ready_gate_a: assert property ((power_suspend || !active_rate_fixed_r)[*4] |-> !data_ready_r)
		else $error("data ready while stopped");
	ready_pulse_a: assert property (data_ready_r |=> !data_ready_r)
		else $error("data ready longer than one cycle");
	cover property (rd12);
	cover property (sh_r[3] && sleep_length_code == 4'hF);
	cover property (power_suspend && active_rate_fixed_r);
	cover property (data_ready_r);
endmodule // accel_rate_asserts

// File: testbench/host_model.sv
// Host side model: register requests and the power-control levels.
// Assumes one request at a time, launched on the rising edge.
`timescale 1ns/10ps
module host_model (
	input  wire logic	clk_sys,
	input  wire logic [7:0]	reg_rdata_r,
	output accel_rate_pkg::reg_req_s	reg_req,
	output logic	power_suspend,
	output logic [3:0]	sleep_length_code
);
	// Idle bus and awake device from time zero
	initial begin
		reg_req = '0;
		power_suspend = 1'b0;
		sleep_length_code = 4'h0;
	end
	// One-cycle write strobe
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_req <= {1'b1, 1'b0, a, d};
		@(posedge clk_sys);
		reg_req <= '0;
	endtask
	// Read data stands one cycle only, so it is taken just after its edge
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_req <= {1'b0, 1'b1, a, 8'h00};
		@(posedge clk_sys);
		reg_req <= '0;
		#1;
		d = reg_rdata_r;
	endtask
	// Rate changes are made under suspend so samples stay trustworthy
	task automatic set_rate(input logic [7:0] d);
		logic keep;
		keep = power_suspend;
		@(posedge clk_sys);
		power_suspend <= 1'b1;
		write(accel_rate_pkg::ADDR_RATE_SELECT, d);
		@(posedge clk_sys);
		power_suspend <= keep;
	endtask
	// Power-control levels: suspend bit and sleep length code
	task automatic set_power(input logic s, input logic [3:0] c);
		@(posedge clk_sys);
		power_suspend <= s;
		sleep_length_code <= c;
	endtask
endmodule // host_model

// File: testbench/tb_top.sv
// Self-checking bench for the rate and output setup block.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/10ps
module tb_top;
	logic	clk_sys = 1'b0;
	logic	rst_b = 1'b0;
	accel_rate_pkg::reg_req_s	reg_req;
	logic [7:0]	reg_rdata_r;
	logic	power_suspend;
	logic [3:0]	sleep_length_code;
	logic	sample_valid = 1'b0;
	accel_rate_pkg::axis_set_s	filtered_sample = '0;
	accel_rate_pkg::axis_set_s	unfiltered_sample = '0;
	logic [19:0]	active_interval_us_r;
	logic	active_rate_fixed_r;
	logic [19:0]	sleep_interval_us_r;
	logic	data_ready_r;
	logic	unfiltered_sel_r;
	logic	guard_off_r;
	int	mismatches = 0;
	int	num_checks = 0;
	logic [7:0]	rd_v;
	// One cycle per microsecond, so a 1000 Hz interval lasts 1000 cycles
	localparam int TB_CPU = 1;
	localparam int SPAN_STOP = 1500;  // Longer than one 1000 us interval
	localparam int SPAN_RUN = 2500;   // Holds exactly two 1000 us pulses
	// Expected intervals in microseconds
	logic [19:0] act_us [8] = '{20'h00000, 20'h01388, 20'h003E8, 20'h007D0, 20'h00FA0, 20'h01F40, 20'h03E80,
		20'h07D00};
	logic [19:0] slp_auto [16] = '{20'h00CEF, 20'h00CEF, 20'h00CEF, 20'h00CEF, 20'h00CEF, 20'h00CEF, 20'h00CEF,
		20'h01388, 20'h02710, 20'h02710, 20'h04E20, 20'h09C40, 20'h0C350, 20'h186A0, 20'h7A120, 20'hF4240};
	logic [19:0] slp_pwr [16] = '{20'h003E8, 20'h003E8, 20'h003E8, 20'h003E8, 20'h003E8, 20'h003E8, 20'h003E8,
		20'h007D0, 20'h00FA0, 20'h01770, 20'h02710, 20'h061A8, 20'h0C350, 20'h186A0, 20'h7A120, 20'hF4240};

	always #2 clk_sys = ~clk_sys;

	accel_rate_and_output_setup #(.CYCLES_PER_US(TB_CPU)) u_dut (.clk_sys, .rst_b, .reg_req, .reg_rdata_r,
		.power_suspend, .sleep_length_code, .sample_valid, .filtered_sample, .unfiltered_sample, .active_interval_us_r,
		.active_rate_fixed_r, .sleep_interval_us_r, .data_ready_r, .unfiltered_sel_r, .guard_off_r);
	host_model u_host (.clk_sys, .reg_rdata_r, .reg_req, .power_suspend, .sleep_length_code);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		u_host.read(a, rd_v);
		chk({12'h000, rd_v}, {12'h000, exp});
	endtask
	// Let registered outputs settle past the edge before looking
	task automatic pause(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// Same sample on all three axes
	task automatic push(input logic [15:0] f, input logic [15:0] u);
		@(posedge clk_sys);
		sample_valid <= 1'b1;
		filtered_sample <= {3{f}};
		unfiltered_sample <= {3{u}};
		@(posedge clk_sys);
		sample_valid <= 1'b0;
	endtask
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_rates();
		rdchk(accel_rate_pkg::ADDR_RATE_SELECT, 8'h00);
		rdchk(accel_rate_pkg::ADDR_OUTPUT_SETUP, 8'h00);
		for (int c = 7; c >= 0; c--) begin
			u_host.set_rate({5'h00, c[2:0]});
			pause(4);
			chk(active_interval_us_r, act_us[c]);
			chk({19'h0, active_rate_fixed_r}, {19'h0, c != 0});
		end
		$display("test rates done");
	endtask
	task automatic t_sleep();
		for (int s = 0; s < 2; s++) begin
			u_host.set_rate({4'h0, s[0], 3'h1});
			for (int c = 0; c < 16; c++) begin
				u_host.set_power(1'b0, c[3:0]);
				pause(3);
				chk(sleep_interval_us_r, (s == 1) ? slp_auto[c] : slp_pwr[c]);
			end
		end
		$display("test sleep done");
	endtask
	task automatic t_setup();
		u_host.write(accel_rate_pkg::ADDR_OUTPUT_SETUP, 8'hFF);
		pause(4);
		rdchk(accel_rate_pkg::ADDR_OUTPUT_SETUP, 8'hC0);
		chk({18'h0, unfiltered_sel_r, guard_off_r}, 20'h00003);
		u_host.set_rate(8'hFF);
		rdchk(accel_rate_pkg::ADDR_RATE_SELECT, 8'h0F);
		rdchk(8'h30, 8'h00);
		u_host.write(accel_rate_pkg::ADDR_SOFT_RESET, 8'h12);
		rdchk(accel_rate_pkg::ADDR_RATE_SELECT, 8'h0F);
		u_host.write(accel_rate_pkg::ADDR_SOFT_RESET, accel_rate_pkg::SOFT_RESET_KEY);
		rdchk(accel_rate_pkg::ADDR_RATE_SELECT, 8'h00);
		rdchk(accel_rate_pkg::ADDR_OUTPUT_SETUP, 8'h00);
		$display("test setup done");
	endtask
	// A sample landing between the two byte reads must not split the pair
	task automatic t_guard();
		pause(3);
		push(16'h1234, 16'h0000);
		rdchk(8'h02, 8'h34);
		push(16'hABCD, 16'h0000);
		rdchk(8'h03, 8'h12);
		u_host.write(accel_rate_pkg::ADDR_OUTPUT_SETUP, 8'h40);
		pause(3);
		rdchk(8'h02, 8'h34);
		push(16'hABCD, 16'h0000);
		rdchk(8'h03, 8'hAB);
		u_host.write(accel_rate_pkg::ADDR_OUTPUT_SETUP, 8'hC0);
		pause(3);
		push(16'h1111, 16'h5AA5);
		rdchk(8'h04, 8'hA5);
		rdchk(8'h05, 8'h5A);
		u_host.write(accel_rate_pkg::ADDR_OUTPUT_SETUP, 8'h40);
		pause(3);
		push(16'h1111, 16'h5AA5);
		rdchk(8'h04, 8'h11);
		$display("test guard done");
	endtask
	// Both spans outlast one interval, so a gate stuck open or shut would show
	task automatic t_suspend();
		int n;
		n = 0;
		u_host.set_rate(8'h02);
		u_host.set_power(1'b1, 4'h0);
		repeat (SPAN_STOP) begin
			pause(1);
			if (data_ready_r !== 1'b0) begin
				n++;
			end
		end
		chk(n[19:0], 20'h00000);
		chk({19'h0, active_rate_fixed_r}, 20'h00001);
		n = 0;
		u_host.set_power(1'b0, 4'h0);
		repeat (SPAN_RUN) begin
			pause(1);
			if (data_ready_r !== 1'b0) begin
				n++;
			end
		end
		chk(n[19:0], 20'h00002);
		$display("test suspend done");
	endtask

	// Watchdog at about three times the five thousand cycles the tests need
	initial begin
		#60000;
		mismatches++;
		print_verdict();
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		pause(2);
		t_rates();
		t_sleep();
		t_setup();
		t_guard();
		t_suspend();
		print_verdict();
	end
endmodule // tb_top

bind accel_rate_and_output_setup accel_rate_asserts u_chk (.clk_sys, .rst_b, .reg_req, .reg_rdata_r,
	.power_suspend, .sleep_length_code, .active_interval_us_r, .active_rate_fixed_r, .sleep_interval_us_r,
	.data_ready_r, .unfiltered_sel_r, .guard_off_r);
